// >>> hw/amc_pkg.sv
// shared constants for the converter operation control block
package amc_pkg;
  // register indices; byte address is four times the index
  localparam logic [3:0]  AMC_IDX_MODE      = 4'h1;
  localparam logic [3:0]  AMC_IDX_STATUS    = 4'h8;
  localparam logic [3:0]  AMC_IDX_CTRL      = 4'h9;
  // converter_operation_control reset value and writable bits
  localparam logic [15:0] AMC_MODE_RESET    = 16'h2000;
  localparam logic [15:0] AMC_MODE_WMASK    = 16'ha77c;
  // field positions
  localparam int          AMC_REF_EN_BIT    = 15;
  localparam int          AMC_SETTLED_BIT   = 13;
  localparam int          AMC_DELAY_LSB     = 8;
  localparam int          AMC_OPMODE_LSB    = 4;
  localparam int          AMC_CLKSEL_LSB    = 2;
  localparam int          AMC_ST_READY_BIT  = 0;
  localparam int          AMC_ST_SETTLE_BIT = 1;
  localparam int          AMC_ST_CAL_BIT    = 2;
  localparam int          AMC_ST_OSC_BIT    = 3;
  localparam int          AMC_CTRL_CR_BIT   = 0;
  // operating modes
  typedef enum logic [2:0] {
    AMC_OP_CONT    = 3'b000,
    AMC_OP_SINGLE  = 3'b001,
    AMC_OP_STANDBY = 3'b010,
    AMC_OP_PWRDN   = 3'b011,
    AMC_OP_INT_OFS = 3'b100,
    AMC_OP_INT_GN  = 3'b101,
    AMC_OP_SYS_OFS = 3'b110,
    AMC_OP_SYS_GN  = 3'b111
  } amc_opmode_t;
  // master clock sources
  typedef enum logic [1:0] {
    AMC_CK_OSC     = 2'b00,
    AMC_CK_OSC_OUT = 2'b01,
    AMC_CK_EXT     = 2'b10,
    AMC_CK_XTAL    = 2'b11
  } amc_clksrc_t;
  // timing: clock rate and switch delays in ns
  localparam int          AMC_CLK_HZ        = 100000000;
  localparam int          AMC_NS_PER_CYC    = 1000000000 / AMC_CLK_HZ;
  localparam int          AMC_DLY1_NS       = 8000;
  localparam int          AMC_DLY2_NS       = 32000;
  localparam int          AMC_DLY3_NS       = 80000;
  localparam int          AMC_DLY4_NS       = 200000;
  localparam int          AMC_DLY5_NS       = 400000;
  localparam int          AMC_DLY6_NS       = 1000000;
  localparam int          AMC_DLY7_NS       = 2000000;
  localparam int          AMC_DLY1_CYC      = AMC_DLY1_NS / AMC_NS_PER_CYC;
  localparam int          AMC_DLY2_CYC      = AMC_DLY2_NS / AMC_NS_PER_CYC;
  localparam int          AMC_DLY3_CYC      = AMC_DLY3_NS / AMC_NS_PER_CYC;
  localparam int          AMC_DLY4_CYC      = AMC_DLY4_NS / AMC_NS_PER_CYC;
  localparam int          AMC_DLY5_CYC      = AMC_DLY5_NS / AMC_NS_PER_CYC;
  localparam int          AMC_DLY6_CYC      = AMC_DLY6_NS / AMC_NS_PER_CYC;
  localparam int          AMC_DLY7_CYC      = AMC_DLY7_NS / AMC_NS_PER_CYC;
  localparam int          AMC_CNT_W         = 18;
endpackage

// >>> hw/amc_settle_timer.sv
// channel-switch settling delay counter
`timescale 1ns/100ps
module amc_settle_timer
  import amc_pkg::*;
#(
  parameter int CNT_W = AMC_CNT_W
)(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // control
  input  wire logic             start,
  input  wire logic             abort,
  input  wire logic [CNT_W-1:0] load_cnt,
  // status
  output logic                  busy,
  output logic                  done
);
  logic [CNT_W-1:0] cnt_r;
  logic             done_r;

  // down counter, restarted on each switch, dropped on abort
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= '0;
    else if (abort)
      cnt_r <= '0;
    else if (start)
      cnt_r <= load_cnt;
    else if (cnt_r != '0)
      cnt_r <= cnt_r - 1'b1;
  end

  // one-cycle pulse when the wait has run out
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      done_r <= 1'b0;
    else
      done_r <= !abort && (start ? (load_cnt == '0) : (cnt_r == 1));
  end

  assign busy = (cnt_r != '0);
  assign done = done_r;

  // check helper: cycles since the last start, against the loaded wait
  logic [CNT_W-1:0] chk_tgt_r;
  logic [CNT_W-1:0] chk_age_r;
  logic             chk_trk_r;

  // tracking stops on abort or once the expected pulse slot has passed
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chk_trk_r <= 1'b0;
      chk_tgt_r <= '0;
      chk_age_r <= '0;
    end
    else if (abort)
      chk_trk_r <= 1'b0;
    else if (start)
    begin
      chk_trk_r <= 1'b1;
      chk_tgt_r <= load_cnt;
      chk_age_r <= '0;
    end
    else if (chk_trk_r && (chk_age_r == chk_tgt_r))
      chk_trk_r <= 1'b0;
    else if (chk_trk_r)
      chk_age_r <= chk_age_r + 1'b1;
  end

  property p_zero_delay;
    @(posedge clk_sys) disable iff (!rst_n)
    start && !abort && load_cnt == '0 |=> done && !busy;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero delay not immediate");

  property p_delay_len;
    @(posedge clk_sys) disable iff (!rst_n)
    chk_trk_r |-> done == (chk_age_r == chk_tgt_r);
  endproperty
  a_delay_len: assert property (p_delay_len) else $error("settle delay wrong length");

  c_long_wait: cover property (@(posedge clk_sys) disable iff (!rst_n) busy [*8] ##1 done);
endmodule

// >>> hw/amc_top.sv
// converter operation control register and its mode, clock and delay logic
// Function
// - mode write restarts filter, clears ready
// - register at index 0x01, 16 bits, resets 0x2000
// - bit 15 enables the reference (ref_enable)
// - bit 13 gives settled-only output, single channel
// - bits 10:8 select channel-switch settling delay
// - bits 6:4 select the operating mode
// - bits 3:2 select the master clock source
// - internal oscillator source also powers oscillator
// - continuous readback only in continuous conversion
`timescale 1ns/100ps
module amc_top
  import amc_pkg::*;
#(
  parameter int DLY4_CYC = AMC_DLY4_CYC,
  parameter int DLY5_CYC = AMC_DLY5_CYC,
  parameter int DLY6_CYC = AMC_DLY6_CYC,
  parameter int DLY7_CYC = AMC_DLY7_CYC
)(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // converter core events
  input  wire logic        channel_switch,
  input  wire logic        single_channel,
  input  wire logic        conv_done,
  // converter core controls
  output logic             filter_reset,
  output logic             conv_start,
  output logic             input_enable,
  output logic             settled_output_only,
  output logic [2:0]       op_mode,
  output logic             cal_active,
  output logic             continuous_readback,
  // reference and clock controls
  output logic             ref_enable,
  output logic             osc_enable,
  output logic             crystal_or_clock_pin_oe,
  output logic             crystal_enable,
  output logic             ext_clock_select
);
  logic             rst_meta_r;
  logic             rst_n_r;
  logic             ack_r;
  logic [31:0]      rdata_r;
  logic [15:0]      mode_r;
  logic             cr_req_r;
  logic             ready_r;
  logic             cal_r;
  logic             frst_r;
  logic             start_r;
  logic             hold_r;
  logic             wr_mode;
  logic             wr_ctrl;
  logic [3:0]       idx;
  logic [15:0]      wdata16;
  logic [AMC_CNT_W-1:0] dly_cnt;
  logic             settle_busy;
  logic             settle_done;
  amc_opmode_t      opm;
  amc_clksrc_t      cks;

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // bus decode; every access answers one cycle after it is raised
  assign idx             = avs_address[5:2];
  assign avs_waitrequest = !ack_r;
  assign wr_mode         = avs_write && ack_r && (idx == AMC_IDX_MODE);
  assign wr_ctrl         = avs_write && ack_r && (idx == AMC_IDX_CTRL);
  assign avs_readdata    = rdata_r;

  // access acknowledge, one cycle per request
  always_ff @(posedge clk_sys or negedge rst_n_r)
  begin
    if (!rst_n_r)
      ack_r <= 1'b0;
    else
      ack_r <= (avs_read || avs_write) && !ack_r;
  end

  // registered read data; unmapped addresses read zero
  always_ff @(posedge clk_sys or negedge rst_n_r)
  begin
    if (!rst_n_r)
      rdata_r <= '0;
    else if (avs_read && !ack_r)
    begin
      unique case (idx)
        AMC_IDX_MODE:   rdata_r <= {16'h0000, mode_r & AMC_MODE_WMASK};
        AMC_IDX_STATUS: rdata_r <= {28'h0000000, osc_enable, cal_r, settle_busy, ready_r};
        AMC_IDX_CTRL:   rdata_r <= {31'h00000000, cr_req_r};
        default:        rdata_r <= '0;
      endcase
    end
  end

  // byte-lane merge for the 16-bit register, reserved bits dropped
  always_comb
  begin
    wdata16 = mode_r;
    if (avs_byteenable[0])
      wdata16[7:0] = avs_writedata[7:0];
    if (avs_byteenable[1])
      wdata16[15:8] = avs_writedata[15:8];
    wdata16 = wdata16 & AMC_MODE_WMASK;
  end

  // converter_operation_control storage
  always_ff @(posedge clk_sys or negedge rst_n_r)
  begin
    if (!rst_n_r)
      mode_r <= AMC_MODE_RESET;
    else if (wr_mode)
      mode_r <= wdata16;
  end

  // continuous readback request
  always_ff @(posedge clk_sys or negedge rst_n_r)
  begin
    if (!rst_n_r)
      cr_req_r <= 1'b0;
    else if (wr_ctrl && avs_byteenable[0])
      cr_req_r <= avs_writedata[AMC_CTRL_CR_BIT];
  end

  // filter reset pulse after each mode write; conversion start unless standby or power-down
  always_ff @(posedge clk_sys or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      frst_r  <= 1'b0;
      start_r <= 1'b0;
    end
    else
    begin
      frst_r  <= wr_mode;
      start_r <= wr_mode && (wdata16[6:4] != AMC_OP_STANDBY) &&
                 (wdata16[6:4] != AMC_OP_PWRDN);
    end
  end

  // result ready: set by a finished conversion, cleared by a mode write
  always_ff @(posedge clk_sys or negedge rst_n_r)
  begin
    if (!rst_n_r)
      ready_r <= 1'b0;
    else if (wr_mode)
      ready_r <= 1'b0;
    else if (conv_done && !hold_r)
      ready_r <= 1'b1;
  end

  // calibration in progress until the core reports it done
  always_ff @(posedge clk_sys or negedge rst_n_r)
  begin
    if (!rst_n_r)
      cal_r <= 1'b0;
    else if (wr_mode)
      cal_r <= wdata16[6];
    else if (conv_done)
      cal_r <= 1'b0;
  end

  // filter held in reset for the cycle after a write
  always_ff @(posedge clk_sys or negedge rst_n_r)
  begin
    if (!rst_n_r)
      hold_r <= 1'b0;
    else
      hold_r <= wr_mode;
  end

  // field views
  assign opm = amc_opmode_t'(mode_r[AMC_OPMODE_LSB +: 3]);
  assign cks = amc_clksrc_t'(mode_r[AMC_CLKSEL_LSB +: 2]);

  // settle delay per code
  always_comb
  begin
    unique case (mode_r[AMC_DELAY_LSB +: 3])
      3'h0: dly_cnt = '0;
      3'h1: dly_cnt = AMC_CNT_W'(AMC_DLY1_CYC);
      3'h2: dly_cnt = AMC_CNT_W'(AMC_DLY2_CYC);
      3'h3: dly_cnt = AMC_CNT_W'(AMC_DLY3_CYC);
      3'h4: dly_cnt = AMC_CNT_W'(DLY4_CYC);
      3'h5: dly_cnt = AMC_CNT_W'(DLY5_CYC);
      3'h6: dly_cnt = AMC_CNT_W'(DLY6_CYC);
      3'h7: dly_cnt = AMC_CNT_W'(DLY7_CYC);
    endcase
  end

  amc_settle_timer #(
    .CNT_W    (AMC_CNT_W)
  ) u_settle (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n_r),
    .start    (channel_switch),
    .abort    (wr_mode),
    .load_cnt (dly_cnt),
    .busy     (settle_busy),
    .done     (settle_done)
  );

  // core controls
  assign filter_reset        = frst_r;
  assign conv_start          = start_r;
  assign input_enable        = !settle_busy && !channel_switch;
  assign settled_output_only = mode_r[AMC_SETTLED_BIT] && single_channel;
  assign op_mode             = opm;
  assign cal_active          = cal_r;
  assign continuous_readback = cr_req_r && (opm == AMC_OP_CONT);
  // reference and clock controls
  assign ref_enable              = mode_r[AMC_REF_EN_BIT];
  assign osc_enable              = (cks == AMC_CK_OSC) || (cks == AMC_CK_OSC_OUT);
  assign crystal_or_clock_pin_oe = (cks == AMC_CK_OSC_OUT);
  assign crystal_enable          = (cks == AMC_CK_XTAL);
  assign ext_clock_select        = (cks == AMC_CK_EXT) || (cks == AMC_CK_XTAL);

  // checks
  property p_write_restart;
    @(posedge clk_sys) disable iff (!rst_n_r)
    wr_mode |=> filter_reset && !settle_busy && !ready_r ##1 !filter_reset;
  endproperty
  a_write_restart: assert property (p_write_restart) else $error("write did not restart");

  property p_reset_value;
    @(posedge clk_sys) disable iff (!rst_n_r)
    !$past(rst_n_r) |-> mode_r == AMC_MODE_RESET;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("bad reset value");

  property p_ref_follow;
    @(posedge clk_sys) disable iff (!rst_n_r)
    wr_mode && avs_byteenable[1] |=> ref_enable == $past(avs_writedata[15]);
  endproperty
  a_ref_follow: assert property (p_ref_follow) else $error("reference enable wrong");

  property p_settled;
    @(posedge clk_sys) disable iff (!rst_n_r)
    settled_output_only |-> single_channel && mode_r[13];
  endproperty
  a_settled: assert property (p_settled) else $error("settled-only without single channel");

  property p_cal_mode;
    @(posedge clk_sys) disable iff (!rst_n_r)
    wr_mode |=> cal_active == (op_mode >= 3'h4) && conv_start == (op_mode[2:1] != 2'b01);
  endproperty
  a_cal_mode: assert property (p_cal_mode) else $error("mode start wrong");

  property p_osc_on;
    @(posedge clk_sys) disable iff (!rst_n_r)
    !mode_r[3] |-> osc_enable && !crystal_enable;
  endproperty
  a_osc_on: assert property (p_osc_on) else $error("oscillator off with internal source");

  property p_reserved_zero;
    @(posedge clk_sys) disable iff (!rst_n_r)
    avs_read && !ack_r && idx == AMC_IDX_MODE |=> (avs_readdata & 32'hffff_5883) == 32'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read set");

  property p_continuous_readback;
    @(posedge clk_sys) disable iff (!rst_n_r)
    continuous_readback |-> op_mode == 3'h0;
  endproperty
  a_continuous_readback: assert property (p_continuous_readback) else $error("continuous readback outside mode");

  c_write_mode: cover property (@(posedge clk_sys) disable iff (!rst_n_r) wr_mode ##1 conv_start);
  c_ready: cover property (@(posedge clk_sys) disable iff (!rst_n_r) $rose(ready_r));
  c_cal_done: cover property (@(posedge clk_sys) disable iff (!rst_n_r) $fell(cal_active));
  c_settle: cover property (@(posedge clk_sys) disable iff (!rst_n_r) settle_done);
endmodule

// >>> bench/amc_core_model.sv
// behavioural converter core that answers conversion starts
`timescale 1ns/100ps
module amc_core_model
#(
  parameter int LAT = 20
)(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // requests from the control block
  input  wire logic conv_start,
  input  wire logic filter_reset,
  // completion back to the control block
  output logic      conv_done
);
  int cnt;
  // a start reloads the count, a bare filter reset kills it; done pulses once
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt       <= 0;
      conv_done <= 1'b0;
    end
    else
    begin
      conv_done <= (cnt == 1);
      if (conv_start)
        cnt <= LAT;
      else if (filter_reset)
        cnt <= 0;
      else if (cnt > 0)
        cnt <= cnt - 1;
    end
  end
endmodule

// >>> bench/testbench.sv
// self-checking bench for the converter operation control block
`timescale 1ns/100ps
module testbench;
  import amc_pkg::*;
  // clock, reset and bus
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  // core side and controls
  logic        channel_switch = 1'b0;
  logic        single_channel = 1'b1;
  logic        conv_done, filter_reset, conv_start, input_enable, settled_output_only;
  logic [2:0]  op_mode;
  logic        cal_active, continuous_readback, ref_enable, osc_enable;
  logic        crystal_or_clock_pin_oe, crystal_enable, ext_clock_select;
  // bookkeeping
  int          n_mismatch = 0;
  int          checked = 0;
  int          k;
  logic [31:0] rd;
  localparam logic [31:0] ROWS [9] = '{32'h8004_8004, 32'h2018_2018, 32'h002c_002c,
    32'h0030_0030, 32'ha340_a340, 32'h0250_0250, 32'h0060_0060, 32'h0470_0470,
    32'hdf9b_8718};
  localparam int DLY [8] = '{0, AMC_DLY1_CYC, AMC_DLY2_CYC, AMC_DLY3_CYC, 40, 50, 60, 70};

  amc_top #(.DLY4_CYC(40), .DLY5_CYC(50), .DLY6_CYC(60), .DLY7_CYC(70)) i_amc_top (
    .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .channel_switch(channel_switch),
    .single_channel(single_channel), .conv_done(conv_done), .filter_reset(filter_reset),
    .conv_start(conv_start), .input_enable(input_enable),
    .settled_output_only(settled_output_only), .op_mode(op_mode), .cal_active(cal_active),
    .continuous_readback(continuous_readback), .ref_enable(ref_enable),
    .osc_enable(osc_enable), .crystal_or_clock_pin_oe(crystal_or_clock_pin_oe),
    .crystal_enable(crystal_enable), .ext_clock_select(ext_clock_select));

  amc_core_model #(.LAT(20)) i_amc_core_model (
    .clk_sys(clk_sys), .reset_n(reset_n), .conv_start(conv_start),
    .filter_reset(filter_reset), .conv_done(conv_done));

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    begin
      checked++;
      if (got !== exp)
      begin
        n_mismatch++;
        $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
    end
  endtask

  // one bus transfer; holds until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d,
                     input logic [3:0] be);
    int n;
    begin
      @(posedge clk_sys);
      avs_address    <= a;
      avs_writedata  <= {16'h0, d};
      avs_byteenable <= be;
      avs_write      <= wr;
      avs_read       <= !wr;
      n = 0;
      do
      begin
        @(posedge clk_sys);
        n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 100);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      if (n >= 100)
        chk(32'h0, 32'h1, "no bus answer");
    end
  endtask

  // mode write, then outputs and readback against the written fields
  task automatic mode_wr(input logic [15:0] d, input logic [15:0] e);
    begin
      bus(1'b1, 6'h04, d, 4'hf);
      #1;
      chk(filter_reset, 1'b1, "filter reset");
      chk(conv_start, e[6:5] != 2'b01, "conv start");
      @(posedge clk_sys);
      #1;
      chk(filter_reset, 1'b0, "filter reset pulse");
      chk(op_mode, e[6:4], "op mode");
      chk(cal_active, e[6], "cal active");
      chk(ref_enable, e[15], "reference");
      chk(settled_output_only, e[13] & single_channel, "settled");
      chk(osc_enable, !e[3], "oscillator");
      chk(crystal_or_clock_pin_oe, e[3:2] == 2'b01, "clock out");
      chk(crystal_enable, e[3:2] == 2'b11, "crystal");
      chk(ext_clock_select, e[3], "external clock");
      bus(1'b0, 6'h04, 16'h0, 4'hf);
      chk(rd, {16'h0, e}, "readback");
    end
  endtask

  // verdict
  task automatic tally_and_finish;
    begin
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  // watchdog
  initial
  begin
    #1000000;
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    foreach (ROWS[i])
      mode_wr(ROWS[i][31:16], ROWS[i][15:0]);
    $display("test table done");
    // settling delay for every code
    for (int c = 0; c < 8; c++)
    begin
      bus(1'b1, 6'h04, {5'h0, 3'(c), 8'h00}, 4'hf);
      repeat (3) @(posedge clk_sys);
      channel_switch <= 1'b1;
      #1;
      chk(input_enable, 1'b0, "switch cycle");
      k = 0;
      do
      begin
        @(posedge clk_sys);
        channel_switch <= 1'b0;
        #1;
        k++;
      end
      while (input_enable !== 1'b1 && k < 9000);
      chk(k, DLY[c] + 1, "settle cycles");
    end
    // mode write aborts a running delay
    bus(1'b1, 6'h04, 16'h0300, 4'hf);
    @(posedge clk_sys);
    channel_switch <= 1'b1;
    @(posedge clk_sys);
    channel_switch <= 1'b0;
    repeat (10) @(posedge clk_sys);
    bus(1'b0, 6'h20, 16'h0, 4'hf);
    chk(rd[3:0], 4'ha, "status busy");
    bus(1'b1, 6'h04, 16'h0000, 4'hf);
    repeat (3) @(posedge clk_sys);
    #1;
    chk(input_enable, 1'b1, "abort delay");
    $display("test settle done");
    // ready set by a result, cleared by a mode write
    repeat (40) @(posedge clk_sys);
    bus(1'b0, 6'h20, 16'h0, 4'hf);
    chk(rd[0], 1'b1, "ready set");
    bus(1'b1, 6'h04, 16'h0000, 4'hf);
    bus(1'b0, 6'h20, 16'h0, 4'hf);
    chk(rd[0], 1'b0, "ready cleared");
    bus(1'b1, 6'h04, 16'h0040, 4'hf);
    repeat (40) @(posedge clk_sys);
    #1;
    chk(cal_active, 1'b0, "cal ends");
    $display("test ready done");
    // continuous readback only in continuous conversion
    bus(1'b1, 6'h04, 16'h0000, 4'hf);
    bus(1'b1, 6'h24, 16'h0001, 4'hf);
    #1;
    chk(continuous_readback, 1'b1, "readback on");
    bus(1'b1, 6'h04, 16'h0010, 4'hf);
    #1;
    chk(continuous_readback, 1'b0, "readback off");
    $display("test readback done");
    // unmapped index and single byte lanes
    bus(1'b1, 6'h0c, 16'hffff, 4'hf);
    bus(1'b0, 6'h0c, 16'h0, 4'hf);
    chk(rd, 32'h0, "unmapped");
    bus(1'b1, 6'h04, 16'hffff, 4'h2);
    bus(1'b0, 6'h04, 16'h0, 4'hf);
    chk(rd, 32'h0000_a710, "upper lane");
    bus(1'b1, 6'h04, 16'h00ff, 4'h1);
    bus(1'b0, 6'h04, 16'h0, 4'hf);
    chk(rd, 32'h0000_a77c, "lower lane");
    $display("test lanes done");
    // second reset in mid-run
    single_channel <= 1'b0;
    reset_n        <= 1'b0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus(1'b0, 6'h04, 16'h0, 4'hf);
    chk(rd, 32'h0000_2000, "reset value");
    chk({ref_enable, osc_enable, op_mode, ext_clock_select}, 6'h10, "reset fields");
    chk(settled_output_only, 1'b0, "settled multi");
    $display("test reset done");
    tally_and_finish();
  end
endmodule
